// file: logic/gpio_pkg.sv
/*
 * gpio_pkg: shared constants of the general purpose io port block, namely
 * register offsets, field widths, reset values and the port spacing.
 * assumes: a single 32-bit ahb-lite slave window of four 64 KiB port spaces.
 */
`default_nettype none
package gpio_pkg;
    localparam int unsigned PIN_COUNT = 12;
    localparam int unsigned PORT_COUNT = 4;
    localparam int unsigned PORT_SPACE_BITS = 16;
    localparam logic [15:0] VALUE_WINDOW_LAST = 16'h3ffc;
    localparam logic [15:0] DIRECTION_OFFSET = 16'h8000;
    localparam logic [15:0] SENSE_OFFSET = 16'h8004;
    localparam logic [15:0] BOTH_EDGE_OFFSET = 16'h8008;
    localparam logic [15:0] POLARITY_OFFSET = 16'h800c;
    localparam logic [15:0] IRQ_MASK_OFFSET = 16'h8010;
    localparam logic [15:0] IRQ_STATUS_OFFSET = 16'h8014;
    localparam int unsigned MASK_ADDR_LSB = 2;
    localparam logic [11:0] REG_RESET = 12'h000;
    localparam int unsigned SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: logic/pin_sync.sv
/*
 * pin_sync: two-flop synchroniser for a vector of pin inputs.
 * assumes: one clock, synchronous active-high reset.
 */
`default_nettype none
module pin_sync import gpio_pkg::*; #(
    parameter int unsigned WIDTH = PIN_COUNT
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    // stage1 feeds only the second flop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// file: logic/pin_irq_detect.sv
/*
 * pin_irq_detect: per-pin edge or level event detection and sticky status.
 * assumes: synchronised pin samples; status cleared by write-one pulses.
 */
`default_nettype none
module pin_irq_detect import gpio_pkg::*; #(
    parameter int unsigned WIDTH = PIN_COUNT
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_sample,
    input wire logic [WIDTH-1:0] sense_bits,
    input wire logic [WIDTH-1:0] both_edge,
    input wire logic [WIDTH-1:0] polarity,
    input wire logic [WIDTH-1:0] clear_bits,
    output logic [WIDTH-1:0] status
);
    logic [WIDTH-1:0] prev_sample;
    logic [WIDTH-1:0] event_hit;
    logic [WIDTH-1:0] next_status;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            always_comb begin
                if (sense_bits[i]) begin
                    event_hit[i] = pin_sample[i] ^ polarity[i];
                end else if (both_edge[i]) begin
                    event_hit[i] = pin_sample[i] ^ prev_sample[i];
                end else if (polarity[i]) begin
                    event_hit[i] = prev_sample[i] & ~pin_sample[i];
                end else begin
                    event_hit[i] = pin_sample[i] & ~prev_sample[i];
                end
            end
        end
    endgenerate

    // set wins over a simultaneous clear so no event is lost
    always_comb begin
        next_status = (status & ~clear_bits) | event_hit;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev_sample <= '0;
            status <= '0;
        end else begin
            prev_sample <= pin_sample;
            status <= next_status;
        end
    end
endmodule
`default_nettype wire

// file: logic/gpio_port_block.sv
/*
 * gpio_port_block: four general purpose io ports behind one ahb-lite slave.
 * assumes: haddr[17:16] picks the port, pins are synchronous-safe after the
 * internal synchroniser, one interrupt line per port.
 */
// Our own choice: register access over AHB-Lite.
// Contract
// - software picks input or output per pin
// - reset: all pins inputs, data zero
// - every pin usable as interrupt input
// - rising, falling or both edges
// - level triggering, per-pin active level
// - reads and writes maskable per pin
// - 32-bit registers, byte/half/word access
// - value register mirrored over 0x0-0x3ffc
// - single-pin address changes only that bit
// - unimplemented pin bits act reserved; irq status still latches and reads back their rising edges
// - ports spaced 64 KiB apart
// - one interrupt line per port
// - direction 0x8000, sense 0x8004
// - address bits 13:2 mask pins
// - direction 1 output, 0 input
// - sense 0 edge, 1 level
// - polarity 0 rising/high, 1 falling/low
`default_nettype none
module gpio_port_block import gpio_pkg::*; #(
    parameter logic [11:0] PORT0_PINS = 12'hfff,
    parameter logic [11:0] PORT1_PINS = 12'hfff,
    parameter logic [11:0] PORT2_PINS = 12'hfff,
    parameter logic [11:0] PORT3_PINS = 12'h03f
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [47:0] port_pin_in,
    output logic [47:0] port_pin_out,
    output logic [47:0] port_pin_oe,
    output logic port0_irq_line,
    output logic port1_irq_line,
    output logic port2_irq_line,
    output logic port3_irq_line
);
    localparam logic [47:0] IMPL = {PORT3_PINS, PORT2_PINS, PORT1_PINS, PORT0_PINS};

    initial begin
        if (PIN_COUNT != 12 || PORT_COUNT != 4) begin
            $error("gpio_port_block serves four ports of twelve pins only");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register state, one 12-bit field per port in each vector
    logic [47:0] pin_value;
    logic [47:0] pin_direction_select;
    logic [47:0] irq_sense_select;
    logic [47:0] irq_both_edge_select;
    logic [47:0] irq_polarity_select;
    logic [47:0] irq_mask;
    logic [47:0] next_pin_value;
    logic [47:0] next_pin_direction_select;
    logic [47:0] next_irq_sense_select;
    logic [47:0] next_irq_both_edge_select;
    logic [47:0] next_irq_polarity_select;
    logic [47:0] next_irq_mask;
    logic [47:0] irq_clear;
    logic [47:0] irq_status;
    logic [47:0] pin_sample;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture
    logic dp_valid;
    logic dp_write;
    logic [1:0] dp_port;
    logic [15:0] dp_offset;
    logic [2:0] dp_size;
    logic [1:0] dp_lane;
    logic next_dp_valid;
    logic next_dp_write;
    logic [1:0] next_dp_port;
    logic [15:0] next_dp_offset;
    logic [2:0] next_dp_size;
    logic [1:0] next_dp_lane;
    logic [31:0] next_hrdata;
    logic addr_take;
    // byte and half-word accesses decode by their word address
    logic [15:0] addr_word;
    assign addr_word = {haddr[15:2], 2'h0};

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_take = hsel && htrans[1] && hready;

    always_comb begin
        next_dp_valid = addr_take;
        next_dp_write = hwrite;
        next_dp_port = haddr[17:16];
        next_dp_offset = addr_word;
        next_dp_size = hsize;
        next_dp_lane = haddr[1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // byte-lane enables: byte, half-word and word all accepted
    logic [31:0] lane_mask;
    always_comb begin
        if (dp_size == 3'h0) begin
            lane_mask = 32'h000000ff << {dp_lane, 3'h0};
        end else if (dp_size == 3'h1) begin
            lane_mask = 32'h0000ffff << {dp_lane[1], 4'h0};
        end else begin
            lane_mask = 32'hffffffff;
        end
    end

    logic [11:0] wmask;
    logic [11:0] wbits;
    logic [11:0] pin_mask;
    logic in_window;
    assign wmask = lane_mask[11:0];
    assign wbits = hwdata[11:0];
    assign in_window = dp_offset <= VALUE_WINDOW_LAST;
    assign pin_mask = dp_offset[MASK_ADDR_LSB +: 12];

    // read value: outputs show the driven value, inputs the pin sample
    logic [47:0] read_value;
    assign read_value = (pin_direction_select & pin_value)
        | (~pin_direction_select & pin_sample);

    ////////////////////////////////////////////////////////////////////////
    // register write decode and read mux
    always_comb begin
        logic [11:0] impl;
        logic [11:0] field;
        int unsigned base;
        impl = 12'h000;
        field = 12'h000;
        base = 0;
        next_pin_value = pin_value;
        next_pin_direction_select = pin_direction_select;
        next_irq_sense_select = irq_sense_select;
        next_irq_both_edge_select = irq_both_edge_select;
        next_irq_polarity_select = irq_polarity_select;
        next_irq_mask = irq_mask;
        irq_clear = '0;
        next_hrdata = 32'h00000000;
        base = 12 * int'(dp_port);
        impl = IMPL[base +: 12];
        if (dp_valid && dp_write) begin
            if (in_window) begin
                field = wmask & pin_mask & impl;
                next_pin_value[base +: 12] = (pin_value[base +: 12] & ~field)
                    | (wbits & field);
            end else if (dp_offset == DIRECTION_OFFSET) begin
                field = wmask & impl;
                next_pin_direction_select[base +: 12] =
                    (pin_direction_select[base +: 12] & ~field) | (wbits & field);
            end else if (dp_offset == SENSE_OFFSET) begin
                field = wmask & impl;
                next_irq_sense_select[base +: 12] =
                    (irq_sense_select[base +: 12] & ~field) | (wbits & field);
            end else if (dp_offset == BOTH_EDGE_OFFSET) begin
                field = wmask & impl;
                next_irq_both_edge_select[base +: 12] =
                    (irq_both_edge_select[base +: 12] & ~field) | (wbits & field);
            end else if (dp_offset == POLARITY_OFFSET) begin
                field = wmask & impl;
                next_irq_polarity_select[base +: 12] =
                    (irq_polarity_select[base +: 12] & ~field) | (wbits & field);
            end else if (dp_offset == IRQ_MASK_OFFSET) begin
                field = wmask & impl;
                next_irq_mask[base +: 12] = (irq_mask[base +: 12] & ~field) | (wbits & field);
            end else if (dp_offset == IRQ_STATUS_OFFSET) begin
                irq_clear[base +: 12] = wmask & wbits & impl;
            end
        end
        // reads decode the live address phase; hrdata is registered for the data phase
        if (addr_take && !hwrite) begin
            base = 12 * int'(haddr[17:16]);
            impl = IMPL[base +: 12];
            if (addr_word <= VALUE_WINDOW_LAST) begin
                next_hrdata[11:0] = read_value[base +: 12] & haddr[13:2] & impl;
            end else if (addr_word == DIRECTION_OFFSET) begin
                next_hrdata[11:0] = pin_direction_select[base +: 12];
            end else if (addr_word == SENSE_OFFSET) begin
                next_hrdata[11:0] = irq_sense_select[base +: 12];
            end else if (addr_word == BOTH_EDGE_OFFSET) begin
                next_hrdata[11:0] = irq_both_edge_select[base +: 12];
            end else if (addr_word == POLARITY_OFFSET) begin
                next_hrdata[11:0] = irq_polarity_select[base +: 12];
            end else if (addr_word == IRQ_MASK_OFFSET) begin
                next_hrdata[11:0] = irq_mask[base +: 12];
            end else if (addr_word == IRQ_STATUS_OFFSET) begin
                next_hrdata[11:0] = irq_status[base +: 12];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_port <= 2'h0;
            dp_offset <= 16'h0000;
            dp_size <= 3'h0;
            dp_lane <= 2'h0;
            hrdata <= 32'h00000000;
            pin_value <= {4{REG_RESET}};
            pin_direction_select <= {4{REG_RESET}};
            irq_sense_select <= {4{REG_RESET}};
            irq_both_edge_select <= {4{REG_RESET}};
            irq_polarity_select <= {4{REG_RESET}};
            irq_mask <= {4{REG_RESET}};
        end else begin
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_port <= next_dp_port;
            dp_offset <= next_dp_offset;
            dp_size <= next_dp_size;
            dp_lane <= next_dp_lane;
            hrdata <= next_hrdata;
            pin_value <= next_pin_value;
            pin_direction_select <= next_pin_direction_select;
            irq_sense_select <= next_irq_sense_select;
            irq_both_edge_select <= next_irq_both_edge_select;
            irq_polarity_select <= next_irq_polarity_select;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: synchroniser, detection, outputs
    pin_sync #(.WIDTH(48)) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(port_pin_in),
        .sync_out(pin_sample)
    );

    pin_irq_detect #(.WIDTH(48)) u_detect (
        .core_clk(core_clk),
        .srst(srst),
        .pin_sample(pin_sample),
        .sense_bits(irq_sense_select & IMPL),
        .both_edge(irq_both_edge_select),
        .polarity(irq_polarity_select),
        .clear_bits(irq_clear),
        .status(irq_status)
    );

    assign port_pin_out = pin_value & IMPL;
    assign port_pin_oe = pin_direction_select & IMPL;

    logic [47:0] pending;
    assign pending = irq_status & irq_mask & IMPL;
    assign port0_irq_line = |pending[11:0];
    assign port1_irq_line = |pending[23:12];
    assign port2_irq_line = |pending[35:24];
    assign port3_irq_line = |pending[47:36];
endmodule
`default_nettype wire

// file: tb/gpio_port_block_sva.sv
/* gpio_port_block_sva: bus, reset and reserved-pin checks at the block ports.
   assumes: bound to gpio_port_block; one clock, srst synchronous active high. */
`default_nettype none
module gpio_port_block_sva import gpio_pkg::*; #(
    parameter logic [11:0] PORT3_PINS = 12'h03f
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [47:0] port_pin_out,
    input wire logic [47:0] port_pin_oe,
    input wire logic port0_irq_line,
    input wire logic port1_irq_line,
    input wire logic port2_irq_line,
    input wire logic port3_irq_line
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire logic taken = hsel && htrans[1] && hready;
    wire logic dir_wr = taken && hwrite && haddr[15:2] == 14'h2000;
    wire logic [3:0] irqs = {port3_irq_line, port2_irq_line, port1_irq_line, port0_irq_line};
    wire logic [11:0] p3_used = port_pin_oe[47:36] | port_pin_out[47:36];
    sequence rd_taken;
        taken && !hwrite;
    endsequence
    sequence hole_rd;
        rd_taken ##0 haddr[15:14] == 2'h1;
    endsequence
    AST_ZERO_WAIT: assert property (hreadyout && !hresp)
        else $error("slave answer not zero-wait okay");
    AST_RST_PINS: assert property ($fell(srst) |-> (port_pin_oe | port_pin_out) == 48'h0)
        else $error("pins not released by reset");
    AST_RST_IRQ: assert property ($fell(srst) |-> irqs == 4'h0)
        else $error("irq line high out of reset");
    AST_IDLE_RD: assert property (!(taken && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    AST_RSV_BITS: assert property (rd_taken |=> hrdata[31:12] == 20'h0)
        else $error("reserved read bits not zero");
    AST_HOLE_RD: assert property (hole_rd |=> hrdata == 32'h0)
        else $error("reserved window read not zero");
    AST_DIR_CAUSE: assert property ($changed(port_pin_oe) |-> $past(dir_wr, 2) || $past(srst))
        else $error("pin direction changed without a direction write");
    AST_PORT3_RSV: assert property ((p3_used & ~PORT3_PINS) == 12'h0)
        else $error("absent port 3 pin driven");
endmodule
bind gpio_port_block gpio_port_block_sva #(.PORT3_PINS(PORT3_PINS)) i_gpio_port_block_sva (.*);
`default_nettype wire

// file: tb/pin_drive_model.sv
/* pin_drive_model: the board side of the port pins.
   assumes: ext_level is what the outside world puts on pins the port leaves undriven. */
`default_nettype none
module pin_drive_model (
    input wire logic [47:0] ext_level,
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    output logic [47:0] pin_level
);
    // a driven pin reads back its own output, so input reads see the pad, not the register
    assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// file: tb/test_gpio_port_block.sv
/* test_gpio_port_block: ahb-lite master, register and pin model, self-checks.
   assumes: zero-wait slave; a pin change reaches status within four clocks. */
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module test_gpio_port_block import gpio_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [47:0] ext = 48'h0;
    logic [47:0] pin_lv;
    logic [47:0] p_out;
    logic [47:0] p_oe;
    logic [3:0] irq;
    logic [15:0] lf = 16'h1012;
    logic [11:0] cfg[5] = '{12'h018, 12'h004, 12'h052, 12'h036, 12'h049};
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int m_dir[4];
    int m_out[4];
    int imp[4] = '{12'hfff, 12'hfff, 12'hfff, 12'h03f};
    gpio_port_block i_gpio_port_block (.core_clk(core_clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .port_pin_in(pin_lv), .port_pin_out(p_out), .port_pin_oe(p_oe),
        .port0_irq_line(irq[0]), .port1_irq_line(irq[1]), .port2_irq_line(irq[2]),
        .port3_irq_line(irq[3]));
    pin_drive_model i_pin_drive_model (.ext_level(ext), .pin_out(p_out), .pin_oe(p_oe),
        .pin_level(pin_lv));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic logic [31:0] ad(int p, logic [15:0] off);
        return 32'h5000_0000 | (32'(p) << 16) | 32'(off);
    endfunction
    function automatic logic ev(logic s, logic b, logic pol, logic a, logic n);
        return s ? n != pol : a != n && (b || n != pol);
    endfunction
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= 2'h2;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, 3'h2, d, r);
    endtask
    initial begin
        logic [31:0] r;
        logic [11:0] e;
        logic [11:0] m;
        int p;
        int k;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (p = 0; p < 4; p++) begin
            bus(ad(p, DIRECTION_OFFSET), 1'b0, 3'h2, 32'h0, r);
            `CHK(r, 32'h0)
            bus(ad(p, SENSE_OFFSET), 1'b0, 3'h2, 32'h0, r);
            `CHK(r, 32'h0)
            wr(ad(p, 16'h4000), 32'hffff_ffff);
            bus(ad(p, 16'h4000), 1'b0, 3'h2, 32'h0, r);
            `CHK(r, 32'h0)
        end
        for (p = 0; p < 4; p++) begin
            k = 3 * p;
            m_dir[p] = rnd() & imp[p];
            ext[12 * p +: 12] <= 12'(rnd());
            wr(ad(p, DIRECTION_OFFSET), 32'(m_dir[p]));
            r = 32'(rnd());
            m_out[p] = (r & imp[p]) ^ ((1 << k) & imp[p]);
            wr(ad(p, VALUE_WINDOW_LAST), r);
            wr(ad(p, 16'(1 << (k + 2))), ~r);
            m = 12'(rnd());
            bus(ad(p, DIRECTION_OFFSET + 16'h1), 1'b1, 3'h0, {20'h0, m[3:0], 8'h0}, r);
            m_dir[p] = (m_dir[p] & 12'h0ff) | ({m[3:0], 8'h0} & imp[p]);
            @(negedge core_clk);
            `CHK(p_oe[12 * p +: 12], 12'(m_dir[p]))
            `CHK(p_out[12 * p +: 12] & p_oe[12 * p +: 12], 12'(m_out[p] & m_dir[p]))
            @(posedge core_clk);
            e = 12'(((m_out[p] & m_dir[p]) | (ext[12 * p +: 12] & ~m_dir[p])) & imp[p]);
            m = 12'(rnd());
            bus(ad(p, {2'h0, m, 2'h0}), 1'b0, 3'h2, 32'h0, r);
            `CHK(r, {20'h0, e & m})
            bus(ad(p, VALUE_WINDOW_LAST), 1'b0, 3'h1, 32'h0, r);
            `CHK(r[15:0], {4'h0, e})
        end
        ext[23:12] <= cfg[3];
        wr(ad(1, DIRECTION_OFFSET), 32'h0);
        wr(ad(1, SENSE_OFFSET), {20'h0, cfg[0]});
        wr(ad(1, BOTH_EDGE_OFFSET), {20'h0, cfg[1]});
        wr(ad(1, POLARITY_OFFSET), {20'h0, cfg[2]});
        wr(ad(1, IRQ_MASK_OFFSET), 32'h7f);
        wr(ad(1, IRQ_STATUS_OFFSET), 32'hfff);
        @(negedge core_clk);
        `CHK(irq, 4'h0)
        @(posedge core_clk);
        ext[23:12] <= cfg[4];
        repeat (4) @(posedge core_clk);
        e = 12'h0;
        for (k = 0; k < 7; k++) e[k] = ev(cfg[0][k], cfg[1][k], cfg[2][k], cfg[3][k], cfg[4][k]);
        bus(ad(1, IRQ_STATUS_OFFSET), 1'b0, 3'h2, 32'h0, r);
        `CHK(r, {20'h0, e})
        `CHK(irq, {2'h0, |e, 1'b0})
        wr(ad(1, IRQ_MASK_OFFSET), 32'h0);
        @(negedge core_clk);
        `CHK(irq, 4'h0)
        @(posedge core_clk);
        wr(ad(1, IRQ_STATUS_OFFSET), 32'hfff);
        bus(ad(1, IRQ_STATUS_OFFSET), 1'b0, 3'h2, 32'h0, r);
        `CHK(r, {20'h0, e & cfg[0]})
        report_and_stop();
    end
endmodule
`default_nettype wire
